// ==== logic/ifb_flag_bank.sv ====
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ifb_flag_bank #(
	parameter logic [1:0] VARIANT = 2'h3
) (
	input wire logic clock,
	input wire logic rst,
	input wire ifb_pkg::ifb_apb_req_type apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pin0_level,
	input wire logic pin1_level,
	input wire ifb_pkg::ifb_event_type events,
	input wire logic stack_full,
	output logic vector_strobe,
	output ifb_pkg::ifb_vector_type vector_index,
	output logic global_irq_enable
);
	import ifb_pkg::*;

	typedef struct packed {
		logic [NUM_REGS-1:0][7:0] regs;
		logic pin0_prev;
		logic pin1_prev;
		logic [3:0] group_prev;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic vec_strobe;
		ifb_vector_type vec_index;
	} ifb_state_type;

	ifb_state_type st;
	ifb_state_type next_st;

	logic [2:0] idx;
	logic hit;
	logic setup;
	logic access;
	logic wr;
	logic [9:0] req;
	logic [9:0] ena;
	logic [9:0] clr;
	logic service;
	ifb_vector_type pick;
	logic [3:0][3:0] gev;
	logic [3:0] ghit;
	logic [3:0] gset;

	always_comb begin
		hit = 1'b1;
		idx = REG_EDGE;
		unique case (apb_req.paddr)
			OFS_EDGE: idx = 3'h0;
			OFS_CTL0: idx = 3'h1;
			OFS_CTL1: idx = 3'h2;
			OFS_CTL2: idx = 3'h3;
			OFS_GRP0: idx = 3'h4;
			OFS_GRP1: idx = 3'h5;
			OFS_GRP2: idx = 3'h6;
			OFS_GRP3: idx = 3'h7;
			default: hit = 1'b0;
		endcase
	end

	assign setup = apb_req.psel & ~apb_req.penable;
	assign access = apb_req.psel & apb_req.penable & st.pready;
	assign wr = access & apb_req.pwrite & hit;

	// Pending requests in priority order, pins first
	assign req = {st.regs[REG_CTL1][BIT_GRP3_REQ],
		st.regs[REG_CTL1][BIT_GRP2_REQ],
		st.regs[REG_CTL0][BIT_GRP1_REQ],
		st.regs[REG_CTL0][BIT_GRP0_REQ],
		st.regs[REG_CTL2][BIT_SERIAL_REQ],
		st.regs[REG_CTL1][BIT_CONV_REQ],
		st.regs[REG_CTL2][BIT_TICK1_REQ],
		st.regs[REG_CTL1][BIT_TICK0_REQ],
		st.regs[REG_CTL2][BIT_PIN1_REQ],
		st.regs[REG_CTL0][BIT_PIN0_REQ]};
	assign ena = {st.regs[REG_CTL1][BIT_GRP3_EN],
		st.regs[REG_CTL1][BIT_GRP2_EN],
		st.regs[REG_CTL0][BIT_GRP1_EN],
		st.regs[REG_CTL0][BIT_GRP0_EN],
		st.regs[REG_CTL2][BIT_SERIAL_EN],
		st.regs[REG_CTL1][BIT_CONV_EN],
		st.regs[REG_CTL2][BIT_TICK1_EN],
		st.regs[REG_CTL1][BIT_TICK0_EN],
		st.regs[REG_CTL2][BIT_PIN1_EN],
		st.regs[REG_CTL0][BIT_PIN0_EN]};

	assign gev = {events.group3, events.group2, events.group1,
		events.group0};

	always_comb begin
		pick = VEC_PIN0;
		clr = 10'h000;
		// Lowest index wins
		for (int k = 9; k >= 0; k--) begin
			if (req[k] & ena[k]) begin
				pick = ifb_vector_type'(k[3:0]);
			end
		end
		// Stack full or global off: nothing acknowledged, flags kept
		service = st.regs[REG_CTL0][BIT_GLOBAL] & |(req & ena)
			& ~stack_full & ~st.vec_strobe;
		if (service) begin
			clr[pick] = 1'b1;
		end
	end

	// Group hit from current member flags and enables
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_group
			assign ghit[g] = |(st.regs[REG_GRP0 + 3'(g)][MEMBER_REQ_LSB +: 4]
				& st.regs[REG_GRP0 + 3'(g)][MEMBER_EN_LSB +: 4]);
			assign gset[g] = ghit[g] & ~st.group_prev[g];
		end
	endgenerate

	always_comb begin
		next_st = st;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		next_st.vec_strobe = service;
		next_st.pin0_prev = pin0_level;
		next_st.pin1_prev = pin1_level;
		next_st.group_prev = ghit;
		if (service) begin
			next_st.vec_index = pick;
		end
		if (setup) begin
			next_st.pready = 1'b1;
			next_st.pslverr = ~hit;
			next_st.prdata = hit ? {24'h00_0000, st.regs[idx]} : 32'h0000_0000;
		end
		if (wr) begin
			next_st.regs[idx] = apb_req.pwdata[7:0];
		end
		// Service clears the served flag and the global enable
		next_st.regs[REG_CTL0][BIT_GLOBAL] =
			next_st.regs[REG_CTL0][BIT_GLOBAL] & ~service;
		next_st.regs[REG_CTL0][BIT_PIN0_REQ] =
			next_st.regs[REG_CTL0][BIT_PIN0_REQ] & ~clr[0];
		next_st.regs[REG_CTL2][BIT_PIN1_REQ] =
			next_st.regs[REG_CTL2][BIT_PIN1_REQ] & ~clr[1];
		next_st.regs[REG_CTL1][BIT_TICK0_REQ] =
			next_st.regs[REG_CTL1][BIT_TICK0_REQ] & ~clr[2];
		next_st.regs[REG_CTL2][BIT_TICK1_REQ] =
			next_st.regs[REG_CTL2][BIT_TICK1_REQ] & ~clr[3];
		next_st.regs[REG_CTL1][BIT_CONV_REQ] =
			next_st.regs[REG_CTL1][BIT_CONV_REQ] & ~clr[4];
		next_st.regs[REG_CTL2][BIT_SERIAL_REQ] =
			next_st.regs[REG_CTL2][BIT_SERIAL_REQ] & ~clr[5];
		next_st.regs[REG_CTL0][BIT_GRP0_REQ] =
			next_st.regs[REG_CTL0][BIT_GRP0_REQ] & ~clr[6];
		next_st.regs[REG_CTL0][BIT_GRP1_REQ] =
			next_st.regs[REG_CTL0][BIT_GRP1_REQ] & ~clr[7];
		next_st.regs[REG_CTL1][BIT_GRP2_REQ] =
			next_st.regs[REG_CTL1][BIT_GRP2_REQ] & ~clr[8];
		next_st.regs[REG_CTL1][BIT_GRP3_REQ] =
			next_st.regs[REG_CTL1][BIT_GRP3_REQ] & ~clr[9];
		// Events set flags last so a set beats any clear
		if (edge_hit(st.regs[REG_EDGE][PIN0_CODE_LSB +: 2], pin0_level,
			st.pin0_prev)) begin
			next_st.regs[REG_CTL0][BIT_PIN0_REQ] = 1'b1;
		end
		if (edge_hit(st.regs[REG_EDGE][PIN1_CODE_LSB +: 2], pin1_level,
			st.pin1_prev)) begin
			next_st.regs[REG_CTL2][BIT_PIN1_REQ] = 1'b1;
		end
		if (events.tick0) begin
			next_st.regs[REG_CTL1][BIT_TICK0_REQ] = 1'b1;
		end
		if (events.conversion_done) begin
			next_st.regs[REG_CTL1][BIT_CONV_REQ] = 1'b1;
		end
		if (events.tick1) begin
			next_st.regs[REG_CTL2][BIT_TICK1_REQ] = 1'b1;
		end
		if (events.serial_port) begin
			next_st.regs[REG_CTL2][BIT_SERIAL_REQ] = 1'b1;
		end
		// Members stay set until software clears them
		for (int k = 0; k < 4; k++) begin
			next_st.regs[REG_GRP0 + 3'(k)][MEMBER_REQ_LSB +: 4] =
				next_st.regs[REG_GRP0 + 3'(k)][MEMBER_REQ_LSB +: 4]
				| gev[k];
		end
		if (gset[0]) begin
			next_st.regs[REG_CTL0][BIT_GRP0_REQ] = 1'b1;
		end
		if (gset[1]) begin
			next_st.regs[REG_CTL0][BIT_GRP1_REQ] = 1'b1;
		end
		if (gset[2]) begin
			next_st.regs[REG_CTL1][BIT_GRP2_REQ] = 1'b1;
		end
		if (gset[3]) begin
			next_st.regs[REG_CTL1][BIT_GRP3_REQ] = 1'b1;
		end
		// Variant trims bits that do not exist
		for (int k = 0; k < NUM_REGS; k++) begin
			next_st.regs[k] = next_st.regs[k]
				& impl_mask(3'(k), VARIANT);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign vector_strobe = st.vec_strobe;
	assign vector_index = st.vec_index;
	assign global_irq_enable = st.regs[REG_CTL0][BIT_GLOBAL];

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence s_pin1_rise;
		st.regs[REG_EDGE][3:2] == 2'b01 && pin1_level && !st.pin1_prev;
	endsequence

	property p_pin1_rise;
		s_pin1_rise |=> st.regs[REG_CTL2][BIT_PIN1_REQ];
	endproperty
	a_pin1_rise: assert property (p_pin1_rise)
		else $error("pin 1 rising edge did not set its flag");

	property p_pin0_off;
		st.regs[REG_EDGE][1:0] == 2'b00 && !st.regs[REG_CTL0][BIT_PIN0_REQ]
			&& !wr && !events.tick0 |=> !st.regs[REG_CTL0][BIT_PIN0_REQ];
	endproperty
	a_pin0_off: assert property (p_pin0_off)
		else $error("disabled pin 0 raised its flag");

	sequence s_read_edge;
		setup && !apb_req.pwrite && apb_req.paddr == OFS_EDGE;
	endsequence

	property p_edge_reserved;
		s_read_edge |=> pready && prdata[31:4] == 28'h000_0000;
	endproperty
	a_edge_reserved: assert property (p_edge_reserved)
		else $error("unimplemented edge bits read non-zero");

	property p_global_gate;
		vector_strobe |-> $past(st.regs[REG_CTL0][BIT_GLOBAL])
			&& !global_irq_enable;
	endproperty
	a_global_gate: assert property (p_global_gate)
		else $error("service without global enable or not cleared after");

	property p_stack_block;
		$past(stack_full) |-> !vector_strobe;
	endproperty
	a_stack_block: assert property (p_stack_block)
		else $error("request acknowledged while stack full");

	property p_event_sets_disabled;
		events.tick0 |=> st.regs[REG_CTL1][BIT_TICK0_REQ];
	endproperty
	a_event_sets_disabled: assert property (p_event_sets_disabled)
		else $error("time base 0 event lost");

	property p_group_set;
		gset[0] |=> st.regs[REG_CTL0][BIT_GRP0_REQ];
	endproperty
	a_group_set: assert property (p_group_set)
		else $error("group 0 flag not set by enabled member");

	property p_pin0_first;
		vector_strobe && $past(req[0] && ena[0]) |-> vector_index == VEC_PIN0;
	endproperty
	a_pin0_first: assert property (p_pin0_first)
		else $error("pin 0 not served first");

	property p_small_variant;
		VARIANT == 2'h0 |-> st.regs[REG_CTL1][4] == 1'b0
			&& st.regs[REG_CTL1][0] == 1'b0;
	endproperty
	a_small_variant: assert property (p_small_variant)
		else $error("group 2 bits present on smallest variant");

	sequence s_grp3_write;
		wr && apb_req.paddr == OFS_GRP3;
	endsequence

	property p_enable_readback;
		s_grp3_write ##1 1'b1 |-> {4'h0, st.regs[3'h7][3:0]}
			== ({4'h0, $past(apb_req.pwdata[3:0])}
			& impl_mask(3'h7, VARIANT));
	endproperty
	a_enable_readback: assert property (p_enable_readback)
		else $error("group 3 enables do not read back as written");

	property p_service_clears;
		vector_strobe && vector_index == VEC_TICK1 && !$past(events.tick1)
			|-> !st.regs[REG_CTL2][BIT_TICK1_REQ];
	endproperty
	a_service_clears: assert property (p_service_clears)
		else $error("served time base 1 flag not cleared");

	property p_pin0_both;
		st.regs[REG_EDGE][1:0] == 2'b11 && pin0_level != st.pin0_prev
			|=> st.regs[REG_CTL0][BIT_PIN0_REQ];
	endproperty
	a_pin0_both: assert property (p_pin0_both)
		else $error("pin 0 edge with both selected did not set its flag");

	property p_pin1_fall;
		st.regs[REG_EDGE][3:2] == 2'b10 && !pin1_level && st.pin1_prev
			|=> st.regs[REG_CTL2][BIT_PIN1_REQ];
	endproperty
	a_pin1_fall: assert property (p_pin1_fall)
		else $error("pin 1 falling edge did not set its flag");

	sequence s_read_ctl0;
		setup && !apb_req.pwrite && apb_req.paddr == OFS_CTL0;
	endsequence

	property p_ctl0_top_zero;
		s_read_ctl0 |=> pready && prdata[31:7] == 25'h000_0000;
	endproperty
	a_ctl0_top_zero: assert property (p_ctl0_top_zero)
		else $error("unimplemented control bit 7 read non-zero");

	property p_global_off_quiet;
		!st.regs[REG_CTL0][BIT_GLOBAL] |=> !vector_strobe;
	endproperty
	a_global_off_quiet: assert property (p_global_off_quiet)
		else $error("interrupt taken with global enable clear");

	property p_no_nesting;
		vector_strobe |=> !vector_strobe;
	endproperty
	a_no_nesting: assert property (p_no_nesting)
		else $error("second service right after the first");

	sequence s_grp0_served;
		service && pick == VEC_GRP0 && !wr;
	endsequence

	property p_member_kept;
		s_grp0_served |=> (st.regs[REG_GRP0][7:4]
			& $past(st.regs[REG_GRP0][7:4]))
			== $past(st.regs[REG_GRP0][7:4]);
	endproperty
	a_member_kept: assert property (p_member_kept)
		else $error("group service cleared a member flag");

	property p_stack_keeps_flag;
		stack_full && st.regs[REG_CTL1][BIT_TICK0_REQ] && !wr
			|=> st.regs[REG_CTL1][BIT_TICK0_REQ];
	endproperty
	a_stack_keeps_flag: assert property (p_stack_keeps_flag)
		else $error("pending flag lost while stack full");

	property p_tick1_sets;
		events.tick1 |=> st.regs[REG_CTL2][BIT_TICK1_REQ];
	endproperty
	a_tick1_sets: assert property (p_tick1_sets)
		else $error("time base 1 event lost");

endmodule
`default_nettype wire

// ==== logic/ifb_pkg.sv ====
package ifb_pkg;

	localparam int NUM_REGS = 8;
	localparam logic [7:0] RESET_REG = 8'h00;

	localparam logic [7:0] OFS_EDGE = 8'h00;
	localparam logic [7:0] OFS_CTL0 = 8'h04;
	localparam logic [7:0] OFS_CTL1 = 8'h08;
	localparam logic [7:0] OFS_CTL2 = 8'h0C;
	localparam logic [7:0] OFS_GRP0 = 8'h10;
	localparam logic [7:0] OFS_GRP1 = 8'h14;
	localparam logic [7:0] OFS_GRP2 = 8'h18;
	localparam logic [7:0] OFS_GRP3 = 8'h1C;

	localparam logic [2:0] REG_EDGE = 3'h0;
	localparam logic [2:0] REG_CTL0 = 3'h1;
	localparam logic [2:0] REG_CTL1 = 3'h2;
	localparam logic [2:0] REG_CTL2 = 3'h3;
	localparam logic [2:0] REG_GRP0 = 3'h4;

	localparam int PIN0_CODE_LSB = 0;
	localparam int PIN1_CODE_LSB = 2;
	localparam int BIT_GLOBAL = 0;
	localparam int BIT_PIN0_EN = 1;
	localparam int BIT_GRP0_EN = 2;
	localparam int BIT_GRP1_EN = 3;
	localparam int BIT_PIN0_REQ = 4;
	localparam int BIT_GRP0_REQ = 5;
	localparam int BIT_GRP1_REQ = 6;
	localparam int BIT_GRP2_EN = 0;
	localparam int BIT_GRP3_EN = 1;
	localparam int BIT_CONV_EN = 2;
	localparam int BIT_TICK0_EN = 3;
	localparam int BIT_GRP2_REQ = 4;
	localparam int BIT_GRP3_REQ = 5;
	localparam int BIT_CONV_REQ = 6;
	localparam int BIT_TICK0_REQ = 7;
	localparam int BIT_TICK1_EN = 0;
	localparam int BIT_PIN1_EN = 1;
	localparam int BIT_SERIAL_EN = 2;
	localparam int BIT_TICK1_REQ = 4;
	localparam int BIT_PIN1_REQ = 5;
	localparam int BIT_SERIAL_REQ = 6;
	localparam int MEMBER_REQ_LSB = 4;
	localparam int MEMBER_EN_LSB = 0;

	typedef enum logic [1:0] {
		EDGE_OFF = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} ifb_edge_type;

	typedef enum logic [3:0] {
		VEC_PIN0 = 4'b0000,
		VEC_PIN1 = 4'b0001,
		VEC_TICK0 = 4'b0010,
		VEC_TICK1 = 4'b0011,
		VEC_CONV = 4'b0100,
		VEC_SERIAL = 4'b0101,
		VEC_GRP0 = 4'b0110,
		VEC_GRP1 = 4'b0111,
		VEC_GRP2 = 4'b1000,
		VEC_GRP3 = 4'b1001
	} ifb_vector_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ifb_apb_req_type;

	// Group member events in flag order: bit 3 is flag bit 7
	typedef struct packed {
		logic tick0;
		logic tick1;
		logic conversion_done;
		logic serial_port;
		logic [3:0] group0;
		logic [3:0] group1;
		logic [3:0] group2;
		logic [3:0] group3;
	} ifb_event_type;

	// Variant 0 smallest, 3 largest
	function automatic logic [7:0] impl_mask(logic [2:0] idx,
		logic [1:0] variant);
		logic [7:0] m;
		m = 8'hFF;
		unique case (idx)
			3'h0: m = 8'h0F;
			3'h1: m = 8'h7F;
			3'h2: m = (variant == 2'h0) ? 8'hEE : 8'hFF;
			3'h3: m = (variant >= 2'h2) ? 8'h77 : 8'h33;
			3'h4: m = (variant >= 2'h2) ? 8'hFF : 8'h33;
			3'h5: m = (variant == 2'h3) ? 8'hFF : 8'h33;
			3'h6: m = (variant == 2'h0) ? 8'h00 : 8'h33;
			3'h7: m = (variant == 2'h0) ? 8'hDD : 8'hFF;
		endcase
		return m;
	endfunction

	function automatic logic edge_hit(logic [1:0] code, logic level,
		logic prev);
		logic rise;
		logic fall;
		rise = level & ~prev;
		fall = ~level & prev;
		return ((code == EDGE_RISE) & rise) | ((code == EDGE_FALL) & fall)
			| ((code == EDGE_BOTH) & (rise | fall));
	endfunction

endpackage

// ==== bench/ifb_event_source.sv ====
`timescale 1ns/100ps
`default_nettype none
module ifb_event_source (
	input wire logic clock,
	output ifb_pkg::ifb_event_type events,
	output var logic pin0_level,
	output var logic pin1_level,
	output var logic stack_full
);
	import ifb_pkg::*;

	initial begin
		events = '0;
		pin0_level = 1'b0;
		pin1_level = 1'b0;
		stack_full = 1'b0;
	end

	// One-cycle pulse, as a peripheral raises its event
	task automatic pulse(input ifb_event_type e);
		@(posedge clock);
		events <= e;
		@(posedge clock);
		events <= '0;
	endtask

	task automatic pins(input logic p0, input logic p1);
		@(posedge clock);
		pin0_level <= p0;
		pin1_level <= p1;
		// Let the bank sample the level before the next read
		@(posedge clock);
	endtask

	task automatic stack(input logic s);
		@(posedge clock);
		stack_full <= s;
	endtask
endmodule
`default_nettype wire

// ==== bench/ifb_flag_bank_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("FAIL %0t got %h exp %h", $time, g, e); end end
module ifb_flag_bank_tb;
	import ifb_pkg::*;

	logic clock;
	logic rst;
	ifb_apb_req_type apb_req;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	ifb_event_type events;
	logic pin0_level;
	logic pin1_level;
	logic stack_full;
	logic vector_strobe;
	ifb_vector_type vector_index;
	logic global_irq_enable;
	int errors = 0;
	int samples_checked = 0;
	int strobes = 0;
	logic [3:0] last_vec = 4'h0;
	logic [31:0] rdata;
	logic [31:0] prdata_small;
	logic [31:0] rdata_small;
	logic err;
	logic [1:0] c;

	ifb_flag_bank #(.VARIANT(2'h3)) u_ifb_flag_bank (
		.clock(clock),
		.rst(rst),
		.apb_req(apb_req),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.pin0_level(pin0_level),
		.pin1_level(pin1_level),
		.events(events),
		.stack_full(stack_full),
		.vector_strobe(vector_strobe),
		.vector_index(vector_index),
		.global_irq_enable(global_irq_enable)
	);

	// Smallest variant shares every input; only its read data is compared
	ifb_flag_bank #(.VARIANT(2'h0)) u_ifb_flag_bank_small (
		.clock(clock),
		.rst(rst),
		.apb_req(apb_req),
		.prdata(prdata_small),
		.pready(),
		.pslverr(),
		.pin0_level(pin0_level),
		.pin1_level(pin1_level),
		.events(events),
		.stack_full(stack_full),
		.vector_strobe(),
		.vector_index(),
		.global_irq_enable()
	);

	ifb_event_source u_ifb_event_source (
		.clock(clock),
		.events(events),
		.pin0_level(pin0_level),
		.pin1_level(pin1_level),
		.stack_full(stack_full)
	);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock) begin
		if (vector_strobe === 1'b1) begin
			strobes <= strobes + 1;
			last_vec <= vector_index;
		end
	end

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		apb_req <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
		@(posedge clock);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdata = prdata;
		rdata_small = prdata_small;
		err = pslverr;
		if (n >= 20) begin
			errors++;
			$display("FAIL %0t no ready", $time);
		end
		apb_req <= '0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		`CHK(rdata, {24'h00_0000, e})
		`CHK(err, 1'b0)
	endtask

	task automatic test_end(input string name);
		$display("test %s done", name);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		test_done();
	end

	initial begin
		apb_req = '0;
		rst = 1'b1;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00);
		xfer(1'b0, 8'h20, 8'h00);
		`CHK(err, 1'b1)
		test_end("reset");
		// Global enable stays off while every other bit is set
		for (int i = 0; i < 8; i++) wr(8'(i * 4), (i == 1) ? 8'hFE : 8'hFF);
		rd(OFS_EDGE, 8'h0F);
		`CHK(rdata_small, 32'h0000_000F)
		rd(OFS_CTL0, 8'h7E);
		`CHK(rdata_small, 32'h0000_007E)
		rd(OFS_CTL1, 8'hFF);
		`CHK(rdata_small, 32'h0000_00EE)
		rd(OFS_CTL2, 8'h77);
		`CHK(rdata_small, 32'h0000_0033)
		rd(OFS_GRP0, 8'hFF);
		`CHK(rdata_small, 32'h0000_0033)
		rd(OFS_GRP1, 8'hFF);
		`CHK(rdata_small, 32'h0000_0033)
		rd(OFS_GRP2, 8'h33);
		`CHK(rdata_small, 32'h0000_0000)
		rd(OFS_GRP3, 8'hFF);
		`CHK(rdata_small, 32'h0000_00DD)
		`CHK(strobes, 0)
		for (int i = 0; i < 8; i++) wr(8'(i * 4), 8'h00);
		test_end("masks");
		u_ifb_event_source.pulse('{tick0: 1'b1, default: '0});
		rd(OFS_CTL1, 8'h80);
		wr(OFS_CTL1, 8'h88);
		repeat (3) @(posedge clock);
		`CHK(strobes, 0)
		u_ifb_event_source.stack(1'b1);
		wr(OFS_CTL0, 8'h01);
		repeat (3) @(posedge clock);
		`CHK(global_irq_enable, 1'b1)
		`CHK(strobes, 0)
		rd(OFS_CTL1, 8'h88);
		u_ifb_event_source.stack(1'b0);
		repeat (3) @(posedge clock);
		`CHK(strobes, 1)
		`CHK(last_vec, 4'h2)
		`CHK(global_irq_enable, 1'b0)
		rd(OFS_CTL1, 8'h08);
		wr(OFS_CTL1, 8'h00);
		test_end("service");
		for (int k = 0; k < 4; k++) begin
			c = k[1:0];
			wr(OFS_EDGE, {4'h0, c, c});
			u_ifb_event_source.pins(1'b1, 1'b1);
			rd(OFS_CTL0, {3'b000, c[0], 4'h0});
			rd(OFS_CTL2, {2'b00, c[0], 5'h00});
			wr(OFS_CTL0, 8'h00);
			wr(OFS_CTL2, 8'h00);
			u_ifb_event_source.pins(1'b0, 1'b0);
			rd(OFS_CTL0, {3'b000, c[1], 4'h0});
			rd(OFS_CTL2, {2'b00, c[1], 5'h00});
			wr(OFS_CTL0, 8'h00);
			wr(OFS_CTL2, 8'h00);
		end
		test_end("edges");
		wr(OFS_EDGE, 8'h01);
		wr(OFS_GRP0, 8'h01);
		wr(OFS_CTL2, 8'h01);
		wr(OFS_CTL0, 8'h06);
		u_ifb_event_source.pins(1'b1, 1'b0);
		u_ifb_event_source.pulse('{tick1: 1'b1, group0: 4'h1, default: '0});
		repeat (2) @(posedge clock);
		rd(OFS_CTL0, 8'h36);
		wr(OFS_CTL0, 8'h37);
		repeat (3) @(posedge clock);
		`CHK(last_vec, 4'h0)
		wr(OFS_CTL0, 8'h27);
		repeat (3) @(posedge clock);
		`CHK(last_vec, 4'h3)
		wr(OFS_CTL0, 8'h27);
		repeat (3) @(posedge clock);
		`CHK(last_vec, 4'h6)
		`CHK(strobes, 4)
		rd(OFS_CTL0, 8'h06);
		rd(OFS_GRP0, 8'h11);
		u_ifb_event_source.pulse('{conversion_done: 1'b1, serial_port: 1'b1,
			default: '0});
		rd(OFS_CTL1, 8'h40);
		rd(OFS_CTL2, 8'h41);
		`CHK(rdata_small, 32'h0000_0001)
		test_end("priority");
		test_done();
	end
endmodule
`default_nettype wire
